//--- rtl/genlock_ctrl_pkg.sv
// genlock_ctrl_pkg: sub-addresses, field positions, reset values and codes
// for the sync-lock and input-gain control registers.
// assumes a byte-wide register write/read port decoded by sub-address.
`default_nettype none
package genlock_ctrl_pkg;
  // sub-addresses
  localparam logic [7:0] SYNC_LOCK_ADDR  = 8'h04;
  localparam logic [7:0] INPUT_GAIN_ADDR = 8'h05;
  localparam logic [7:0] GAIN_ADJ_ADDR   = 8'h1D;
  // reset values
  localparam logic [7:0] SYNC_LOCK_RST   = 8'h09;
  localparam logic [7:0] INPUT_GAIN_RST  = 8'h10;
  // sync_lock_control fields
  localparam int ASPECT_BIT     = 7;
  localparam int FREEZE_BIT     = 6;
  localparam int DUTY_BIT       = 5;
  localparam int LINE_BIT       = 4;
  localparam int HMISS_BIT      = 3;
  localparam int VMISS_BIT      = 2;
  localparam int CLKSEL_LSB     = 0;
  // input_gain_control fields
  localparam int LOSS_LSB       = 6;
  localparam int GAIN_LSB       = 4;
  localparam int AAF_BIT        = 3;
  localparam int INSEL_LSB      = 0;
  // miss thresholds
  localparam logic [3:0] HMISS_LONG = 4'hC;
  localparam logic [3:0] VMISS_LONG = 4'h3;
  localparam logic [3:0] MISS_ONE   = 4'h1;
  // gain mode codes
  localparam logic [1:0] GAIN_UNITY  = 2'h0;
  localparam logic [1:0] GAIN_AUTO   = 2'h1;
  localparam logic [1:0] GAIN_FIXED  = 2'h2;
  localparam logic [1:0] GAIN_FREEZE = 2'h3;
  // lock-loss codes
  localparam logic [1:0] LOSS_AUTO   = 2'h0;
  localparam logic [1:0] LOSS_KEEP   = 2'h1;
  localparam logic [1:0] LOSS_SWITCH = 2'h2;
  // output colour formats (from the output format register)
  localparam logic [2:0] FMT_YC16   = 3'h0;
  localparam logic [2:0] FMT_YC8    = 3'h1;
  localparam logic [2:0] FMT_PAR656 = 3'h2;
  localparam logic [2:0] FMT_RGB15  = 3'h3;
  localparam logic [2:0] FMT_RGB16  = 3'h4;
  typedef enum logic [1:0] {FRZ_RUN, FRZ_PEND, FRZ_HELD, FRZ_RESUME} freeze_state_t;
endpackage : genlock_ctrl_pkg
`default_nettype wire

//--- rtl/sync_miss_counter.sv
// sync_miss_counter: counts consecutive missing sync pulses and pulses
// acquire_out when the selected threshold is reached.
// assumes miss/seen strobes are one-cycle pulses on sys_clk_in.
`default_nettype none
module sync_miss_counter
(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rstn_in,
  // sync events
  input  wire logic       miss_in,
  input  wire logic       seen_in,
  input  wire logic [3:0] limit_in,
  // result
  output logic            acquire_out
);
  logic [3:0] count_r;

  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      count_r     <= 4'h0;
      acquire_out <= 1'b0;
    end
    else
    begin
      acquire_out <= 1'b0;
      if (seen_in)
        count_r <= 4'h0;
      else if (miss_in)
      begin
        // restart after firing so a persistent loss keeps re-requesting acquisition
        if (count_r + 4'h1 >= limit_in)
        begin
          count_r     <= 4'h0;
          acquire_out <= 1'b1;
        end
        else
          count_r <= count_r + 4'h1;
      end
    end
  end
endmodule : sync_miss_counter
`default_nettype wire

//--- rtl/pixel_valid_gen.sv
// pixel_valid_gen: forms the pixel-valid strobe from format and timing bits.
// assumes pixel_rate_in, line and active strobes come from the same clock.
`default_nettype none
module pixel_valid_gen
(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rstn_in,
  // configuration
  input  wire logic [2:0] out_format_in,
  input  wire logic       duty_sel_in,
  input  wire logic       line_sel_in,
  // timing
  input  wire logic       pixel_rate_in,
  input  wire logic       line_lock_in,
  input  wire logic       active_video_in,
  input  wire logic       active_line_in,
  input  wire logic       line_time_in,
  input  wire logic       pixel_clock_in,
  // strobe
  output logic            pixel_valid_strobe_out
);
  logic wide_mode;
  logic pace;
  logic window;
  logic strobe_nxt;

  always_comb
  begin
    wide_mode = (out_format_in == genlock_ctrl_pkg::FMT_YC16)
             || (out_format_in == genlock_ctrl_pkg::FMT_RGB15)
             || (out_format_in == genlock_ctrl_pkg::FMT_RGB16);
    pace   = duty_sel_in ? line_lock_in : pixel_rate_in;
    window = line_sel_in ? line_time_in
                         : (active_video_in && active_line_in);
    if (wide_mode)
      strobe_nxt = pace && window;
    else
      // duty bit ignored in the 8-bit modes
      strobe_nxt = line_sel_in ? (active_video_in && pixel_clock_in)
                               : active_video_in;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
      pixel_valid_strobe_out <= 1'b0;
    else
      pixel_valid_strobe_out <= strobe_nxt;
  end
endmodule : pixel_valid_gen
`default_nettype wire

//--- rtl/genlock_input_ctrl.sv
// genlock_input_ctrl: sync-lock and input-gain control registers with
// their effect on timing freeze, lock acquisition, gain fallback and input routing.
// assumes a byte write/read port from the serial control bus slave on sys_clk_in;
// video timing strobes are same-clock, the pixel clock pin is synchronised here.
`default_nettype none
module genlock_input_ctrl
(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rstn_in,
  // register port
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic [7:0]      reg_rdata_out,
  output logic            reg_ack_out,
  // video timing
  input  wire logic [2:0] out_format_in,
  input  wire logic       field_end_in,
  input  wire logic       field_start_in,
  input  wire logic       hsync_seen_in,
  input  wire logic       hsync_miss_in,
  input  wire logic       vsync_seen_in,
  input  wire logic       vsync_miss_in,
  input  wire logic       locked_in,
  input  wire logic       pixel_rate_in,
  input  wire logic       line_lock_in,
  input  wire logic       active_video_in,
  input  wire logic       active_line_in,
  input  wire logic       line_time_in,
  input  wire logic       pixel_clock_in,
  // control outputs
  output logic            square_pixel_out,
  output logic            timing_frozen_out,
  output logic            h_acquire_out,
  output logic            v_acquire_out,
  output logic [1:0]      pixel_clock_sel_out,
  output logic [1:0]      agc_mode_out,
  output logic            gain_from_adjust_out,
  output logic            aaf_bypass_out,
  output logic [1:0]      input_select_out,
  output logic            input_luma_chroma_out,
  output logic            pixel_valid_strobe_out
);
  logic [7:0]  sync_lock_control_r;
  logic [7:0]  input_gain_control_r;
  logic        lock_lost;
  logic        locked_d_r;
  logic        pclk_meta_r;
  logic        pclk_sync_r;
  logic        h_acq;
  logic        v_acq;
  logic [1:0]  gain_mode;
  logic [1:0]  loss_sel;
  logic [1:0]  gain_nxt;
  genlock_ctrl_pkg::freeze_state_t frz_r;

  function automatic logic [7:0] read_mux(input logic [7:0] a,
                                          input logic [7:0] s,
                                          input logic [7:0] g);
    if (a == genlock_ctrl_pkg::SYNC_LOCK_ADDR)
      read_mux = s;
    else if (a == genlock_ctrl_pkg::INPUT_GAIN_ADDR)
      read_mux = g;
    else
      read_mux = 8'h00;
  endfunction : read_mux

  assign gain_mode = input_gain_control_r[genlock_ctrl_pkg::GAIN_LSB +: 2];
  assign loss_sel  = input_gain_control_r[genlock_ctrl_pkg::LOSS_LSB +: 2];
  assign lock_lost = locked_d_r && !locked_in;

  // gain fallback on sync loss
  always_comb
  begin
    gain_nxt = gain_mode;
    if (lock_lost && gain_mode != genlock_ctrl_pkg::GAIN_AUTO)
    begin
      case (loss_sel)
        genlock_ctrl_pkg::LOSS_AUTO:   gain_nxt = genlock_ctrl_pkg::GAIN_AUTO;
        genlock_ctrl_pkg::LOSS_KEEP:   gain_nxt = gain_mode;
        genlock_ctrl_pkg::LOSS_SWITCH:
          if (gain_mode == genlock_ctrl_pkg::GAIN_FREEZE)
            gain_nxt = genlock_ctrl_pkg::GAIN_AUTO;
        default:                       gain_nxt = gain_mode;
      endcase
    end
  end

  // registers; a host write to the input-gain register in the same cycle as a sync loss wins
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      sync_lock_control_r  <= genlock_ctrl_pkg::SYNC_LOCK_RST;
      input_gain_control_r <= genlock_ctrl_pkg::INPUT_GAIN_RST;
    end
    else
    begin
      if (reg_wr_in && reg_addr_in == genlock_ctrl_pkg::SYNC_LOCK_ADDR)
        sync_lock_control_r <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == genlock_ctrl_pkg::INPUT_GAIN_ADDR)
        input_gain_control_r <= reg_wdata_in;
      else
        input_gain_control_r[genlock_ctrl_pkg::GAIN_LSB +: 2] <= gain_nxt;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      reg_rdata_out <= 8'h00;
      reg_ack_out   <= 1'b0;
    end
    else
    begin
      reg_ack_out <= reg_wr_in || reg_rd_in;
      if (reg_rd_in)
        reg_rdata_out <= read_mux(reg_addr_in, sync_lock_control_r, input_gain_control_r);
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      locked_d_r  <= 1'b0;
      pclk_meta_r <= 1'b0;
      pclk_sync_r <= 1'b0;
    end
    else
    begin
      locked_d_r  <= locked_in;
      pclk_meta_r <= pixel_clock_in;
      pclk_sync_r <= pclk_meta_r;
    end
  end

  // freeze sequencing tied to field boundaries
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
      frz_r <= genlock_ctrl_pkg::FRZ_RUN;
    else
    begin
      case (frz_r)
        genlock_ctrl_pkg::FRZ_RUN:
          if (sync_lock_control_r[genlock_ctrl_pkg::FREEZE_BIT])
            frz_r <= genlock_ctrl_pkg::FRZ_PEND;
        genlock_ctrl_pkg::FRZ_PEND:
          if (!sync_lock_control_r[genlock_ctrl_pkg::FREEZE_BIT])
            frz_r <= genlock_ctrl_pkg::FRZ_RUN;
          else if (field_end_in)
            frz_r <= genlock_ctrl_pkg::FRZ_HELD;
        genlock_ctrl_pkg::FRZ_HELD:
          if (!sync_lock_control_r[genlock_ctrl_pkg::FREEZE_BIT])
            frz_r <= genlock_ctrl_pkg::FRZ_RESUME;
        genlock_ctrl_pkg::FRZ_RESUME:
          if (sync_lock_control_r[genlock_ctrl_pkg::FREEZE_BIT])
            frz_r <= genlock_ctrl_pkg::FRZ_HELD;
          else if (field_start_in)
            frz_r <= genlock_ctrl_pkg::FRZ_RUN;
        default:
          frz_r <= genlock_ctrl_pkg::FRZ_RUN;
      endcase
    end
  end

  sync_miss_counter u_hmiss
  (
    .sys_clk_in  (sys_clk_in),
    .rstn_in     (rstn_in),
    .miss_in     (hsync_miss_in),
    .seen_in     (hsync_seen_in),
    .limit_in    (sync_lock_control_r[genlock_ctrl_pkg::HMISS_BIT]
                  ? genlock_ctrl_pkg::MISS_ONE : genlock_ctrl_pkg::HMISS_LONG),
    .acquire_out (h_acq)
  );

  sync_miss_counter u_vmiss
  (
    .sys_clk_in  (sys_clk_in),
    .rstn_in     (rstn_in),
    .miss_in     (vsync_miss_in),
    .seen_in     (vsync_seen_in),
    .limit_in    (sync_lock_control_r[genlock_ctrl_pkg::VMISS_BIT]
                  ? genlock_ctrl_pkg::MISS_ONE : genlock_ctrl_pkg::VMISS_LONG),
    .acquire_out (v_acq)
  );

  pixel_valid_gen u_valid
  (
    .sys_clk_in             (sys_clk_in),
    .rstn_in                (rstn_in),
    .out_format_in          (out_format_in),
    .duty_sel_in            (sync_lock_control_r[genlock_ctrl_pkg::DUTY_BIT]),
    .line_sel_in            (sync_lock_control_r[genlock_ctrl_pkg::LINE_BIT]),
    .pixel_rate_in          (pixel_rate_in),
    .line_lock_in           (line_lock_in),
    .active_video_in        (active_video_in),
    .active_line_in         (active_line_in),
    .line_time_in           (line_time_in),
    .pixel_clock_in         (pclk_sync_r),
    .pixel_valid_strobe_out (pixel_valid_strobe_out)
  );

  // aspect and clock fields of the sync-lock register
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      square_pixel_out    <= 1'b0;
      pixel_clock_sel_out <= 2'h1;
    end
    else
    begin
      square_pixel_out    <= sync_lock_control_r[genlock_ctrl_pkg::ASPECT_BIT];
      // reserved code 11 passed through; the host must not program it
      pixel_clock_sel_out <= sync_lock_control_r[genlock_ctrl_pkg::CLKSEL_LSB +: 2];
    end
  end

  // frozen from the held field until the next field start
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
      timing_frozen_out <= 1'b0;
    else
      timing_frozen_out <= (frz_r == genlock_ctrl_pkg::FRZ_HELD)
                        || (frz_r == genlock_ctrl_pkg::FRZ_RESUME);
  end

  // acquisition requests, one cycle each
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      h_acquire_out <= 1'b0;
      v_acquire_out <= 1'b0;
    end
    else
    begin
      h_acquire_out <= h_acq;
      v_acquire_out <= v_acq;
    end
  end

  // effective gain mode seen by the gain loop
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      agc_mode_out         <= genlock_ctrl_pkg::GAIN_AUTO;
      gain_from_adjust_out <= 1'b0;
    end
    else
    begin
      // lock-loss 10: auto until lock, then fixed gain
      if (loss_sel == genlock_ctrl_pkg::LOSS_SWITCH && gain_mode != genlock_ctrl_pkg::GAIN_AUTO)
        agc_mode_out <= locked_in ? genlock_ctrl_pkg::GAIN_FIXED
                                  : genlock_ctrl_pkg::GAIN_AUTO;
      else
        agc_mode_out <= gain_mode;
      gain_from_adjust_out <= (gain_mode == genlock_ctrl_pkg::GAIN_FIXED);
    end
  end

  // input routing; reserved 1xx codes fall back to composite input 1
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      aaf_bypass_out        <= 1'b0;
      input_select_out      <= 2'h0;
      input_luma_chroma_out <= 1'b0;
    end
    else
    begin
      aaf_bypass_out <= input_gain_control_r[genlock_ctrl_pkg::AAF_BIT];
      if (input_gain_control_r[genlock_ctrl_pkg::INSEL_LSB + 2])
      begin
        input_select_out      <= 2'h0;
        input_luma_chroma_out <= 1'b0;
      end
      else
      begin
        input_select_out <= input_gain_control_r[genlock_ctrl_pkg::INSEL_LSB +: 2];
        input_luma_chroma_out <= (input_gain_control_r[genlock_ctrl_pkg::INSEL_LSB +: 2] == 2'h3);
      end
    end
  end
endmodule : genlock_input_ctrl
`default_nettype wire

//--- verif/genlock_input_ctrl_checker.sv
// genlock_input_ctrl_checker: port-level assertions on the control registers.
// assumes a bind into genlock_input_ctrl; sees only its ports.
`default_nettype none
module genlock_input_ctrl_checker
(
  // clock and reset
  input wire logic       sys_clk_in,
  input wire logic       rstn_in,
  // register port
  input wire logic       reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  // video timing
  input wire logic       field_end_in,
  input wire logic       field_start_in,
  input wire logic       hsync_miss_in,
  input wire logic       vsync_miss_in,
  // control outputs
  input wire logic       square_pixel_out,
  input wire logic       timing_frozen_out,
  input wire logic       h_acquire_out,
  input wire logic       v_acquire_out,
  input wire logic [1:0] pixel_clock_sel_out,
  input wire logic       aaf_bypass_out,
  input wire logic [1:0] input_select_out,
  input wire logic       input_luma_chroma_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  logic w4;
  logic w5;
  logic hsel_r;
  assign w4 = reg_wr_in && reg_addr_in == 8'h04;
  assign w5 = reg_wr_in && reg_addr_in == 8'h05;
  // shadow of the horizontal miss select, resets to single-pulse mode
  always_ff @(posedge sys_clk_in)
    if (!rstn_in) hsel_r <= 1'b1;
    else if (w4) hsel_r <= reg_wdata_in[3];
  a_square_follows: assert property (w4 |-> ##2 square_pixel_out == $past(reg_wdata_in[7], 2))
    else $error("square pixel output does not follow write");
  a_clksel_follows: assert property (w4 |-> ##2 pixel_clock_sel_out == $past(reg_wdata_in[1:0], 2))
    else $error("clock select does not follow write");
  a_aaf_follows: assert property (w5 |-> ##2 aaf_bypass_out == $past(reg_wdata_in[3], 2))
    else $error("filter bypass does not follow write");
  a_luma_chroma_sel: assert property (w5 |-> ##2 input_luma_chroma_out == ($past(reg_wdata_in[2:0], 2) == 3'h3))
    else $error("luma chroma select wrong");
  a_composite_sel: assert property (w5 && reg_wdata_in[2:0] < 3'h3 |-> ##2 input_select_out == $past(reg_wdata_in[1:0], 2))
    else $error("composite select wrong");
  a_hacq_single: assert property (hsel_r && hsync_miss_in && !w4 |-> ##2 h_acquire_out)
    else $error("no acquire after single missing line sync");
  a_hacq_cause: assert property (h_acquire_out |-> $past(hsync_miss_in, 2))
    else $error("line acquire without a miss");
  a_vacq_cause: assert property (v_acquire_out |-> $past(vsync_miss_in, 2))
    else $error("field acquire without a miss");
  a_freeze_start: assert property ($rose(timing_frozen_out) |-> $past(field_end_in, 2))
    else $error("freeze not at field end");
  a_freeze_stop: assert property ($fell(timing_frozen_out) |-> $past(field_start_in, 2))
    else $error("resume not at field start");
endmodule : genlock_input_ctrl_checker
bind genlock_input_ctrl genlock_input_ctrl_checker genlock_input_ctrl_checker_i (.sys_clk_in,
  .rstn_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in, .field_end_in, .field_start_in,
  .hsync_miss_in, .vsync_miss_in, .square_pixel_out, .timing_frozen_out, .h_acquire_out,
  .v_acquire_out, .pixel_clock_sel_out, .aaf_bypass_out, .input_select_out,
  .input_luma_chroma_out);
`default_nettype wire

//--- verif/host_model.sv
// host_model: serial-bus host side reduced to the byte register port.
// assumes the device acks one cycle after it takes a strobe.
`default_nettype none
module host_model
(
  // clock
  input  wire logic       sys_clk_in,
  // register port
  input  wire logic       ack_in,
  output logic            wr_out,
  output logic            rd_out,
  output logic [7:0]      addr_out,
  output logic [7:0]      wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // one-cycle strobe; address and data held until the ack edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic ok);
    @(negedge sys_clk_in);
    wr_out <= wr;
    rd_out <= !wr;
    addr_out <= a;
    wdata_out <= d;
    @(negedge sys_clk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    ok = (ack_in === 1'b1);
    @(negedge sys_clk_in);
    // released lines show the inverse rather than a stale value
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask : xfer
endmodule : host_model
`default_nettype wire

//--- verif/video_decoder_genlock_input_ctrl_tb_top.sv
// video_decoder_genlock_input_ctrl_tb_top: self-checking bench for genlock_input_ctrl.
// assumes host_model and the bound checker are compiled before it.
`default_nettype none
module video_decoder_genlock_input_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rstn, wr, rd, ack, locked, sq, frz, hacq, vacq, gadj, aaf, lc, pvs;
  logic [7:0] addr, wdata, rdata, d;
  logic [2:0] fmt;
  logic [1:0] clksel, agc, insel;
  logic [5:0] ev, tm, lt[6];
  logic [7:0] exp_q[$];
  logic       rd_seen, ok;
  int         error_cnt, total_checks, hcnt, vcnt, h0, v0;
  logic [7:0] sl;
  logic       p1, p2, wide;
  logic       pv_q[$];
  genlock_input_ctrl genlock_input_ctrl_i (.sys_clk_in(clk), .rstn_in(rstn), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .reg_ack_out(ack), .out_format_in(fmt), .field_end_in(ev[3]), .field_start_in(ev[4]),
    .hsync_seen_in(ev[2]), .hsync_miss_in(ev[0]), .vsync_seen_in(ev[5]),
    .vsync_miss_in(ev[1]), .locked_in(locked), .pixel_rate_in(tm[0]), .line_lock_in(tm[1]),
    .active_video_in(tm[2]), .active_line_in(tm[3]), .line_time_in(tm[4]),
    .pixel_clock_in(tm[5]), .square_pixel_out(sq), .timing_frozen_out(frz),
    .h_acquire_out(hacq), .v_acquire_out(vacq), .pixel_clock_sel_out(clksel),
    .agc_mode_out(agc), .gain_from_adjust_out(gadj), .aaf_bypass_out(aaf),
    .input_select_out(insel), .input_luma_chroma_out(lc), .pixel_valid_strobe_out(pvs));
  host_model host_model_i (.sys_clk_in(clk), .ack_in(ack), .wr_out(wr), .rd_out(rd),
    .addr_out(addr), .wdata_out(wdata));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic give_verdict;
    if (error_cnt == 0 && total_checks > 0 && exp_q.size() == 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] v);
    if (!w)
      exp_q.push_back(v);
    host_model_i.xfer(w, a, w ? v : 8'h00, ok);
    if (!ok)
    begin
      error_cnt++;
      give_verdict();
    end
  endtask : xfer
  // which: 0 line miss, 1 field miss, 2 line seen, 3 field end, 4 field start, 5 field seen
  task automatic pulse(input int which, input int n);
    repeat (n)
    begin
      @(negedge clk);
      ev <= 6'h01 << which;
      @(negedge clk);
      ev <= 6'h00;
    end
    repeat (2) @(negedge clk);
  endtask : pulse
  always @(posedge clk) rd_seen <= rd;
  always @(posedge clk) hcnt <= hcnt + (hacq === 1'b1);
  always @(posedge clk) vcnt <= vcnt + (vacq === 1'b1);
  // strobe model: shadow of the sync-lock register and a two-flop pixel clock path
  always @(posedge clk)
  begin
    wide = (fmt == 3'h0) || (fmt == 3'h3) || (fmt == 3'h4);
    if (!rstn)
      pv_q.push_back(1'b0);
    else if (wide)
      pv_q.push_back((sl[5] ? tm[1] : tm[0]) && (sl[4] ? tm[4] : tm[2] && tm[3]));
    else
      pv_q.push_back(tm[2] && (!sl[4] || p2));
    sl <= !rstn ? 8'h09 : (wr && addr == 8'h04) ? wdata : sl;
    p1 <= rstn && tm[5];
    p2 <= rstn && p1;
  end
  always @(negedge clk)
    check({7'h00, pvs}, {7'h00, pv_q.pop_front()});
  // read results come back one cycle after the strobe
  always @(negedge clk)
    if (ack === 1'b1 && rd_seen === 1'b1)
      check(rdata, exp_q.size() > 0 ? exp_q.pop_front() : ~rdata);
  // free-running timing levels keep the strobe path busy
  always @(negedge clk)
  begin
    tm <= 6'($urandom);
    fmt <= 3'($urandom_range(4, 0));
  end
  initial
  begin
    {rstn, locked, ev, tm, fmt, hcnt, vcnt, error_cnt, total_checks} = '0;
    locked = 1'b1;
    void'($urandom(32'h8FB01700));
    repeat (3) @(negedge clk);
    rstn <= 1'b1;
    check({sq, 1'b0, clksel, 2'h0, agc}, 8'h11);
    xfer(0, 8'h04, 8'h09);
    xfer(0, 8'h05, 8'h10);
    xfer(0, 8'h06, 8'h00);
    h0 = hcnt;
    pulse(0, 3);
    check(8'(hcnt - h0), 8'h03);
    xfer(1, 8'h04, 8'h01);
    pulse(0, 11);
    pulse(2, 1);
    pulse(0, 12);
    check(8'(hcnt - h0), 8'h04);
    v0 = vcnt;
    pulse(1, 2);
    pulse(5, 1);
    pulse(1, 3);
    check(8'(vcnt - v0), 8'h01);
    xfer(1, 8'h04, 8'h05);
    pulse(1, 2);
    check(8'(vcnt - v0), 8'h03);
    for (int i = 0; i < 4; i++)
    begin
      d = (8'($urandom) & 8'hBC) | 8'(i);
      xfer(1, 8'h04, d);
      check({sq, 5'h00, clksel}, {d[7], 5'h00, d[1:0]});
      xfer(0, 8'h04, d);
    end
    xfer(1, 8'h07, 8'hFF);
    xfer(0, 8'h07, 8'h00);
    xfer(0, 8'h04, d);
    for (int i = 0; i < 8; i++)
    begin
      d = {2'h1, 2'(i), i[0], 3'(i)};
      xfer(1, 8'h05, d);
      check({aaf, gadj, agc, lc, 1'b0, insel}, {i[0], i[1:0] == 2'h2, 2'(i), i == 3, 1'b0,
        (i > 3) ? 2'h0 : 2'(i)});
      xfer(0, 8'h05, d);
    end
    lt = '{6'h09, 6'h1A, 6'h2D, 6'h20, 6'h05, 6'h1F};
    foreach (lt[k])
    begin
      xfer(1, 8'h05, {lt[k][5:2], 4'h0});
      check({6'h00, agc},
        {6'h00, (lt[k][5:4] == 2'h2 && lt[k][3:2] != 2'h1) ? 2'h2 : lt[k][3:2]});
      locked <= 1'b0;
      repeat (3) @(negedge clk);
      check({6'h00, agc}, {6'h00, (lt[k][5:4] == 2'h2) ? 2'h1 : lt[k][1:0]});
      xfer(0, 8'h05, {lt[k][5:4], lt[k][1:0], 4'h0});
      locked <= 1'b1;
    end
    xfer(1, 8'h04, 8'h41);
    pulse(4, 1);
    check({7'h00, frz}, 8'h00);
    pulse(3, 1);
    check({7'h00, frz}, 8'h01);
    xfer(1, 8'h04, 8'h01);
    pulse(3, 1);
    check({7'h00, frz}, 8'h01);
    pulse(4, 1);
    check({7'h00, frz}, 8'h00);
    give_verdict();
  end
endmodule : video_decoder_genlock_input_ctrl_tb_top
`default_nettype wire
